/* hdl/sgt_pkg.sv */
/*
  Shared constants for the serial gateway toggle handshake block:
  control and status word field positions, sizes and init timing.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sgt_pkg;
  // ==========================================================
  // Process image sizes
  localparam int unsigned SLOTS        = 22;
  localparam int unsigned TX_DEPTH     = 128;
  localparam int unsigned RX_DEPTH     = 128;
  // ==========================================================
  // Control word fields
  localparam int unsigned CW_TX_REQ    = 0;
  localparam int unsigned CW_RX_ACC    = 1;
  localparam int unsigned CW_INIT      = 2;
  localparam int unsigned CW_CONT      = 3;
  localparam int unsigned CW_LEN_LSB   = 8;
  // ==========================================================
  // Status word fields
  localparam int unsigned SW_TX_ACC    = 0;
  localparam int unsigned SW_RX_REQ    = 1;
  localparam int unsigned SW_INIT_ACC  = 2;
  localparam int unsigned SW_BUF_FULL  = 3;
  localparam int unsigned SW_PAR_ERR   = 4;
  localparam int unsigned SW_FRM_ERR   = 5;
  localparam int unsigned SW_OVR_ERR   = 6;
  localparam int unsigned SW_LEN_LSB   = 8;
  // ==========================================================
  // Reset value and buffer-full level
  localparam logic [15:0] SW_RESET     = 16'h0000;
  localparam logic [7:0]  BUF_FULL_LVL = 8'h78;
  // ==========================================================
  // Init settle time, 100 MHz clock
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned INIT_NS      = 100;
  localparam int unsigned INIT_CYC     = (INIT_NS * CLK_MHZ + 999) / 1000;
endpackage : sgt_pkg

/* hdl/sgt_fifo_if.sv */
/*
  Byte stream carrier between the gateway and its FIFO.
  Assumes one clock for both ends.
*/
`timescale 1ns/100ps
interface sgt_fifo_if;
  logic       wr_valid;
  logic       wr_ready;
  logic [7:0] wr_data;
  logic       rd_valid;
  logic       rd_ready;
  logic [7:0] rd_data;
  logic       flush;
  logic [7:0] level;
  modport owner (output wr_valid, output wr_data, input wr_ready,
                 output rd_ready, input rd_valid, input rd_data,
                 output flush, input level);
  modport fifo  (input wr_valid, input wr_data, output wr_ready,
                 input rd_ready, output rd_valid, output rd_data,
                 input flush, output level);
endinterface : sgt_fifo_if

/* hdl/sgt_fifo.sv */
/*
  Byte FIFO with flush, used for the send and receive buffers.
  Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module sgt_fifo #(
  parameter int unsigned DEPTH = 128
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  sgt_fifo_if.fifo  f
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [7:0]  mem [DEPTH];
  logic [AW:0] wp, rp, next_wp, next_rp;
  logic        full, empty;

  assign full       = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty      = (wp == rp);
  assign f.wr_ready = !full;
  assign f.rd_valid = !empty;
  assign f.rd_data  = mem[rp[AW-1:0]];
  assign f.level    = 8'(wp - rp);

  always_comb begin
    next_wp = wp;
    next_rp = rp;
    if (f.flush) begin
      next_wp = '0;
      next_rp = '0;
    end else begin
      if (f.wr_valid && !full) next_wp = wp + 1'b1;
      if (f.rd_ready && !empty) next_rp = rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (f.wr_valid && !full && !f.flush) mem[wp[AW-1:0]] <= f.wr_data;
  end
endmodule // sgt_fifo

/* hdl/sgt_gateway.sv */
/*
  Device side of the cyclic process-data handshake of a serial gateway.
  Assumes the process image words arrive once per controller cycle on
  the clock of this block; the serial line side is a byte stream with
  error flags from a separate framer, already on this clock.
*/
// Operation
// [R1] Controller puts tx count 1..22 in upper byte
// [R2] Controller toggles bit 0 when tx bytes valid
// [R3] Device takes bytes, toggles tx-accepted status bit; code misses a bit 0 toggle made during load or send
// [R4] Controller waits for tx-accepted before next block
// [R5] Controller toggles bit 1 after taking rx bytes
// [R6] No new rx block before rx-accepted toggle
// [R7] Init request blocks traffic, resets pointers, reloads
// [R8] Status bit 2 reports init done
// [R9] Controller clears init request to resume
// [R10] Rising bit 3 sends whole transmit buffer
// [R11] Status bit 2 marks send done, bit 3 clears
// [R12] Slot 0 is sent first
// [R13] Slot 0 holds earliest received byte
// [R14] Toggle status bit 1 when rx bytes valid
// [R15] Upper status byte reports rx count 1..22
// [R16] Line errors set flags, character discarded
// [R17] Toggle seen by compare with previous sample
`timescale 1ns/100ps
module sgt_gateway #(
  parameter int unsigned SLOTS = sgt_pkg::SLOTS
) (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic [15:0]          ctrl_word_i,
  input  wire logic [SLOTS*8-1:0]   data_out_i,
  input  wire logic                 cont_mode_i,
  output logic      [15:0]          status_word_o,
  output logic      [SLOTS*8-1:0]   data_in_o,
  output logic                      ser_tx_valid_o,
  output logic      [7:0]           ser_tx_data_o,
  input  wire logic                 ser_tx_ready_i,
  input  wire logic                 ser_rx_valid_i,
  input  wire logic [7:0]           ser_rx_data_i,
  input  wire logic                 ser_rx_par_err_i,
  input  wire logic                 ser_rx_frm_err_i,
  output logic                      line_reload_o
);
  // ==========================================================
  // State
  typedef enum logic [3:0] {
    SGT_RUN  = 4'b0001,
    SGT_INIT = 4'b0010,
    SGT_LOAD = 4'b0100,
    SGT_SEND = 4'b1000
  } sgt_state_t;

  sgt_state_t  state, next_state;
  logic [15:0] ctrl_q, next_ctrl_q;
  logic [15:0] status, next_status;
  logic [SLOTS*8-1:0] din, next_din;
  logic [7:0]  idx, next_idx;
  logic [7:0]  len, next_len;
  logic [7:0]  rx_cnt, next_rx_cnt;
  logic        rx_pending, next_rx_pending;
  logic [7:0]  settle, next_settle;
  logic        tx_valid, next_tx_valid;
  logic [7:0]  tx_data, next_tx_data;
  logic        reload, next_reload;

  sgt_fifo_if txf ();
  sgt_fifo_if rxf ();

  sgt_fifo #(.DEPTH(sgt_pkg::TX_DEPTH)) u_txf (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .f         (txf)
  );
  sgt_fifo #(.DEPTH(sgt_pkg::RX_DEPTH)) u_rxf (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .f         (rxf)
  );

  function automatic logic [7:0] slot(input logic [SLOTS*8-1:0] v,
                                      input logic [7:0] i);
    slot = v[i*8 +: 8];
  endfunction

  // ==========================================================
  // Edge detection on the control word
  logic tx_req_tgl, rx_acc_tgl, cont_rise, init_req;
  assign tx_req_tgl = ctrl_word_i[sgt_pkg::CW_TX_REQ] !=
                      ctrl_q[sgt_pkg::CW_TX_REQ];                // [R17]
  assign rx_acc_tgl = ctrl_word_i[sgt_pkg::CW_RX_ACC] !=
                      ctrl_q[sgt_pkg::CW_RX_ACC];                // [R17]
  assign cont_rise  = ctrl_word_i[sgt_pkg::CW_CONT] &&
                      !ctrl_q[sgt_pkg::CW_CONT];
  assign init_req   = ctrl_word_i[sgt_pkg::CW_INIT];
  logic [7:0] req_len;
  assign req_len = ctrl_word_i[sgt_pkg::CW_LEN_LSB +: 8];
  logic overrun;
  assign overrun = ser_rx_valid_i && !rxf.wr_ready;

  // Serial receive into FIFO; bad characters dropped
  assign rxf.wr_valid = ser_rx_valid_i && !ser_rx_par_err_i &&
                        !ser_rx_frm_err_i && state != SGT_INIT;  // [R16]
  assign rxf.wr_data  = ser_rx_data_i;
  assign rxf.flush    = init_req;                                // [R7]
  assign txf.flush    = init_req;                                // [R7]
  assign txf.wr_valid = state == SGT_LOAD && idx != len;         // [R12]
  assign txf.wr_data  = slot(data_out_i, idx);                   // [R12]
  // Drain to line in send state, refill rx block while idle
  assign txf.rd_ready = state == SGT_SEND && (!tx_valid || ser_tx_ready_i);
  assign rxf.rd_ready = state == SGT_RUN && !rx_pending &&
                        rx_cnt < 8'(SLOTS) && !init_req;

  // ==========================================================
  // Next state
  always_comb begin
    next_state      = state;
    next_ctrl_q     = ctrl_word_i;
    next_status     = status;
    next_din        = din;
    next_idx        = idx;
    next_len        = len;
    next_rx_cnt     = rx_cnt;
    next_rx_pending = rx_pending;
    next_settle     = settle;
    next_tx_valid   = tx_valid && !ser_tx_ready_i;
    next_tx_data    = tx_data;
    next_reload     = 1'b0;
    // Error flags are sticky; cleared only by init, where the clear wins over a set
    if (ser_rx_valid_i && ser_rx_par_err_i)
      next_status[sgt_pkg::SW_PAR_ERR] = 1'b1;                   // [R16]
    if (ser_rx_valid_i && ser_rx_frm_err_i)
      next_status[sgt_pkg::SW_FRM_ERR] = 1'b1;                   // [R16]
    if (overrun) next_status[sgt_pkg::SW_OVR_ERR] = 1'b1;        // [R16]
    next_status[sgt_pkg::SW_BUF_FULL] = rxf.level >= sgt_pkg::BUF_FULL_LVL;
    if (txf.rd_ready && txf.rd_valid) begin
      next_tx_valid = 1'b1;
      next_tx_data  = txf.rd_data;
    end
    if (rx_acc_tgl) next_rx_pending = 1'b0;                      // [R6]
    case (state)
      SGT_RUN: begin
        if (rxf.rd_ready && rxf.rd_valid) begin
          next_din[rx_cnt*8 +: 8] = rxf.rd_data;                 // [R13]
          next_rx_cnt = rx_cnt + 8'h01;
        end else if (!rx_pending && rx_cnt != 8'h00 && !rx_acc_tgl) begin
          next_status[sgt_pkg::SW_LEN_LSB +: 8] = rx_cnt;        // [R15]
          next_status[sgt_pkg::SW_RX_REQ] =
            !status[sgt_pkg::SW_RX_REQ];                         // [R14]
          next_rx_pending = 1'b1;                                // [R6]
          next_rx_cnt = 8'h00;
        end
        if (cont_rise && !cont_mode_i) begin
          next_status[sgt_pkg::SW_INIT_ACC] = 1'b0;
        end
        if (!ctrl_word_i[sgt_pkg::CW_CONT] && cont_mode_i)
          next_status[sgt_pkg::SW_INIT_ACC] = 1'b0;              // [R11]
        if (init_req) begin
          next_state  = SGT_INIT;
          next_settle = 8'(sgt_pkg::INIT_CYC);
          next_reload = 1'b1;                                    // [R7]
        end else if (cont_mode_i && cont_rise) begin
          next_state = SGT_SEND;                                 // [R10]
        end else if (tx_req_tgl) begin
          next_idx = 8'h00;
          next_len = (req_len > 8'(SLOTS)) ? 8'(SLOTS) : req_len;
          next_state = SGT_LOAD;                                 // [R3]
        end
      end
      SGT_LOAD: begin
        if (idx == len || !txf.wr_ready) begin
          next_status[sgt_pkg::SW_TX_ACC] =
            !status[sgt_pkg::SW_TX_ACC];                         // [R3]
          next_state = cont_mode_i ? SGT_RUN : SGT_SEND;
        end else begin
          next_idx = idx + 8'h01;                                // [R12]
        end
      end
      SGT_SEND: begin
        if (!txf.rd_valid && !tx_valid) begin
          if (cont_mode_i)
            next_status[sgt_pkg::SW_INIT_ACC] = 1'b1;            // [R11]
          next_state = SGT_RUN;
        end
      end
      SGT_INIT: begin
        next_rx_cnt     = 8'h00;
        next_rx_pending = 1'b0;
        next_tx_valid   = 1'b0;
        next_status[sgt_pkg::SW_PAR_ERR] = 1'b0;
        next_status[sgt_pkg::SW_FRM_ERR] = 1'b0;
        next_status[sgt_pkg::SW_OVR_ERR] = 1'b0;
        if (settle != 8'h00) next_settle = settle - 8'h01;
        else next_status[sgt_pkg::SW_INIT_ACC] = 1'b1;           // [R8]
        if (!init_req) begin
          next_status[sgt_pkg::SW_INIT_ACC] = 1'b0;              // [R9]
          next_state = SGT_RUN;
        end
      end
      default: next_state = SGT_RUN;
    endcase
    // Init preempts load and send at once
    if (init_req && state != SGT_INIT) begin
      next_state  = SGT_INIT;
      next_settle = 8'(sgt_pkg::INIT_CYC);
      next_reload = 1'b1;                                        // [R7]
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state      <= SGT_RUN;
      ctrl_q     <= 16'h0000;
      status     <= sgt_pkg::SW_RESET;
      din        <= '0;
      idx        <= 8'h00;
      len        <= 8'h00;
      rx_cnt     <= 8'h00;
      rx_pending <= 1'b0;
      settle     <= 8'h00;
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
      reload     <= 1'b0;
    end else begin
      state      <= next_state;
      ctrl_q     <= next_ctrl_q;
      status     <= next_status;
      din        <= next_din;
      idx        <= next_idx;
      len        <= next_len;
      rx_cnt     <= next_rx_cnt;
      rx_pending <= next_rx_pending;
      settle     <= next_settle;
      tx_valid   <= next_tx_valid;
      tx_data    <= next_tx_data;
      reload     <= next_reload;
    end
  end

  assign status_word_o  = status;
  assign data_in_o      = din;
  assign ser_tx_valid_o = tx_valid;
  assign ser_tx_data_o  = tx_data;
  assign line_reload_o  = reload;
endmodule // sgt_gateway

/* verification/sgt_gateway_asserts.sv */
/*
  Port checker for the gateway handshake, bound onto sgt_gateway.
  Assumes one clock and the asynchronous active-high reset.
*/
`timescale 1ns/100ps
module sgt_gateway_asserts (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] ctrl_word_i,
  input  wire logic [15:0] status_word_o,
  input  wire logic        ser_tx_valid_o,
  input  wire logic [7:0]  ser_tx_data_o,
  input  wire logic        ser_tx_ready_i,
  input  wire logic        line_reload_o
);
  // ==========================================================
  // Toggle history and init length
  logic [1:0] ctrl_prev, next_ctrl_prev, stat_prev, next_stat_prev;
  logic       tx_pend, next_tx_pend, rx_pend, next_rx_pend;
  logic [4:0] init_cnt, next_init_cnt;
  always_comb begin
    next_ctrl_prev = ctrl_word_i[1:0];
    next_stat_prev = status_word_o[1:0];
    next_tx_pend = (ctrl_word_i[0] != ctrl_prev[0]) ||
                   (tx_pend && status_word_o[0] == stat_prev[0]);
    next_rx_pend = (status_word_o[1] != stat_prev[1]) ||
                   (rx_pend && ctrl_word_i[1] == ctrl_prev[1]);
    next_init_cnt = !ctrl_word_i[2] ? 5'h00 :
                    (init_cnt == 5'h1f) ? init_cnt : init_cnt + 5'h01;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_prev <= 2'h0;
      stat_prev <= 2'h0;
      tx_pend <= 1'b0;
      rx_pend <= 1'b0;
      init_cnt <= 5'h00;
    end else begin
      ctrl_prev <= next_ctrl_prev;
      stat_prev <= next_stat_prev;
      tx_pend <= next_tx_pend;
      rx_pend <= next_rx_pend;
      init_cnt <= next_init_cnt;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Init may drop a stalled byte
  sequence s_stall;
    ser_tx_valid_o && !ser_tx_ready_i && !ctrl_word_i[2];
  endsequence
  sequence s_init_rise;
    $rose(ctrl_word_i[2]);
  endsequence
  a_tx_cause: assert property (
    status_word_o[0] != stat_prev[0] |-> tx_pend)
    else $error("tx accept toggled without a request");
  a_rx_wait: assert property (
    status_word_o[1] != stat_prev[1] |-> !rx_pend)
    else $error("rx block offered before acknowledge");
  a_rx_count: assert property (
    status_word_o[1] != stat_prev[1] |->
      status_word_o[15:8] inside {[8'h01:8'h16]})
    else $error("rx count out of range");
  a_tx_hold: assert property (
    s_stall |=> ser_tx_valid_o && $stable(ser_tx_data_o))
    else $error("tx byte dropped while stalled");
  a_reload_start: assert property (
    s_init_rise |-> ##[0:4] line_reload_o)
    else $error("no line reload after init request");
  a_reload_pulse: assert property (
    line_reload_o |=> !line_reload_o)
    else $error("line reload longer than one cycle");
  a_init_done: assert property (
    init_cnt >= 5'h14 |-> status_word_o[2])
    else $error("init accepted flag missing");
  a_init_quiet: assert property (
    init_cnt >= 5'h03 |-> !ser_tx_valid_o && status_word_o[6:4] == 3'h0)
    else $error("traffic or error flags during init");
  a_init_release: assert property (
    $fell(ctrl_word_i[2]) |-> ##[1:4] !status_word_o[2])
    else $error("init accepted flag not cleared");
endmodule // sgt_gateway_asserts

bind sgt_gateway sgt_gateway_asserts i_chk (
  .clk_i          (clk_i),
  .sys_rst_i      (sys_rst_i),
  .ctrl_word_i    (ctrl_word_i),
  .status_word_o  (status_word_o),
  .ser_tx_valid_o (ser_tx_valid_o),
  .ser_tx_data_o  (ser_tx_data_o),
  .ser_tx_ready_i (ser_tx_ready_i),
  .line_reload_o  (line_reload_o)
);

/* verification/sgt_ctl_model.sv */
/*
  Fieldbus controller model: drives control word and tx slots.
  Assumes the status word comes back on the same clock.
*/
`timescale 1ns/100ps
module sgt_ctl_model (
  input  wire logic [15:0]                 status_word_i,
  input  wire logic                        clk_i,
  output logic      [15:0]                 ctrl_word_o,
  output logic      [sgt_pkg::SLOTS*8-1:0] data_out_o
);
  // ==========================================================
  // Idle at reset release
  initial begin
    ctrl_word_o = 16'h0000;
    data_out_o = '0;
  end
  // ==========================================================
  // Handshake tasks
  task automatic wait_bit(input int b, input logic v, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(posedge clk_i);
      #1;
      ok = (status_word_i[b] === v);
    end
  endtask
  task automatic send_block(input logic [7:0] n,
                            input logic [sgt_pkg::SLOTS*8-1:0] d,
                            output bit ok);
    logic exp;
    exp = ~status_word_i[0];
    @(posedge clk_i);
    #1;
    data_out_o = d;
    ctrl_word_o[15:8] = n;
    ctrl_word_o[0] = ~ctrl_word_o[0];
    wait_bit(0, exp, ok);
  endtask
  task automatic set_ctl(input int b, input logic v);
    @(posedge clk_i);
    #1;
    ctrl_word_o[b] = v;
  endtask
endmodule // sgt_ctl_model

/* verification/tb.sv */
/*
  Testbench for sgt_gateway: controller model on the process image,
  serial line driven and captured here. Assumes a 100 MHz clock.
*/
`timescale 1ns/100ps
module tb;
  logic                        clk_i, sys_rst_i, cont_mode, tx_ready;
  logic                        rx_valid, par_err, frm_err;
  logic [7:0]                  rx_data;
  logic [15:0]                 ctrl_word, status_word;
  logic [sgt_pkg::SLOTS*8-1:0] data_out, data_in;
  logic                        tx_valid, line_reload;
  logic [7:0]                  tx_data;
  logic [7:0]                  cap[$];
  int                          failures, n_compared;
  bit                          ok;
  sgt_ctl_model i_ctl (.clk_i(clk_i), .status_word_i(status_word),
    .ctrl_word_o(ctrl_word), .data_out_o(data_out));
  sgt_gateway i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ctrl_word_i(ctrl_word), .data_out_i(data_out), .cont_mode_i(cont_mode),
    .status_word_o(status_word), .data_in_o(data_in),
    .ser_tx_valid_o(tx_valid), .ser_tx_data_o(tx_data),
    .ser_tx_ready_i(tx_ready), .ser_rx_valid_i(rx_valid),
    .ser_rx_data_i(rx_data), .ser_rx_par_err_i(par_err),
    .ser_rx_frm_err_i(frm_err), .line_reload_o(line_reload));
  // ==========================================================
  // Clock, stalling line and capture
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    tx_ready <= #1 ~tx_ready;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      cap.push_back(tx_data);
  end
  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_cap(input int base, input int n);
    check("tx_count", cap.size(), n);
    for (int i = 0; i < n && i < cap.size(); i++)
      check("tx_byte", cap[i], 8'h11 * (base + i));
    cap.delete();
  endtask
  task automatic send_char(input logic [7:0] d, input logic p, f);
    @(posedge clk_i);
    #1;
    {rx_valid, rx_data, par_err, frm_err} = {1'b1, d, p, f};
    @(posedge clk_i);
    #1;
    {rx_valid, rx_data, par_err, frm_err} = {1'b0, ~d, 2'b00};
  endtask
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200us;
    failures++;
    finish_test();
  end
  // ==========================================================
  // Tests
  initial begin
    {sys_rst_i, cont_mode, tx_ready, rx_valid, par_err, frm_err} = 6'h20;
    rx_data = 8'h00;
    failures = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    check("status_reset", status_word, sgt_pkg::SW_RESET);
    i_ctl.send_block(8'h03, 176'h332211, ok);
    check("tx_accept", ok, 1);
    repeat (30) @(posedge clk_i);
    check_cap(1, 3);
    $display("Test transmit block done");
    send_char(8'h5a, 1'b0, 1'b0);
    i_ctl.wait_bit(1, 1'b1, ok);
    check("rx_toggle", ok, 1);
    check("rx_count", status_word[15:8], 8'h01);
    check("rx_slot0", data_in[7:0], 8'h5a);
    send_char(8'ha1, 1'b0, 1'b0);
    send_char(8'ha2, 1'b1, 1'b0);
    send_char(8'ha3, 1'b0, 1'b1);
    send_char(8'ha4, 1'b0, 1'b0);
    repeat (30) @(posedge clk_i);
    check("rx_held", status_word[1], 1'b1);
    check("rx_errs", status_word[5:4], 2'b11);
    i_ctl.set_ctl(1, ~ctrl_word[1]);
    i_ctl.wait_bit(1, 1'b0, ok);
    check("rx_next", {ok, status_word[15:8], data_in[15:0]},
          25'h102a4a1);
    // Block pending, so the receive buffer fills and overruns
    for (int i = 0; i < 129; i++)
      send_char(8'(i), 1'b0, 1'b0);
    check("rx_overrun", status_word[6:3], 4'hf);
    $display("Test receive blocks done");
    i_ctl.set_ctl(2, 1'b1);
    @(posedge clk_i);
    #1 check("reload", line_reload, 1'b1);
    i_ctl.wait_bit(2, 1'b1, ok);
    check("init_done", {ok, status_word[6:4]}, 4'h8);
    repeat (20) @(posedge clk_i);
    i_ctl.set_ctl(2, 1'b0);
    i_ctl.wait_bit(2, 1'b0, ok);
    check("init_release", ok, 1);
    $display("Test init done");
    @(posedge clk_i);
    #1 cont_mode = 1'b1;
    i_ctl.send_block(8'h02, 176'h5544, ok);
    i_ctl.send_block(8'h01, 176'h66, ok);
    repeat (20) @(posedge clk_i);
    check("cont_held", cap.size(), 0);
    i_ctl.set_ctl(3, 1'b1);
    i_ctl.wait_bit(2, 1'b1, ok);
    check("cont_done", ok, 1);
    check_cap(4, 3);
    i_ctl.set_ctl(3, 1'b0);
    i_ctl.wait_bit(2, 1'b0, ok);
    check("cont_clear", ok, 1);
    $display("Test continuous send done");
    finish_test();
  end
endmodule // tb
